// file: hw/asoc_delay.sv
// Fixed-length delay line carrying result words toward the output pins
module asoc_delay
  import asoc_pkg::*;
#(
  parameter int WIDTH = DATA_W + 1,
  parameter int DEPTH = LATENCY - 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // ==========================================================================
  // Stage storage
  logic [WIDTH-1:0] stage_ff     [DEPTH];
  logic [WIDTH-1:0] nxt_stage    [DEPTH];

  // Shift one stage per edge
  always_comb begin
    nxt_stage[0] = din;
    for (int i = 1; i < DEPTH; i++) begin
      nxt_stage[i] = stage_ff[i-1];
    end
  end

  // Register the stages
  always_ff @(posedge aclk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!aresetn) begin
        stage_ff[i] <= '0;
      end else begin
        stage_ff[i] <= nxt_stage[i];
      end
    end
  end

  assign dout = stage_ff[DEPTH-1];

endmodule // asoc_delay

// file: hw/asoc_top.sv
// Converter output control: sampling, result pipeline, pins, AXI4-Lite regs
// What this block does
// - Result appears after fifth following rising edge
// - Both mode pins low means power-down
// - Mode 01 gain one, 10 gain half
// - Output enable deasserted releases the data pins
// - Results are unsigned straight binary, clamped
// - Over-range flag travels with its own result
// - Reference select low internal, high external
// - Output enable acts independent of sample timing
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
module asoc_top
  import asoc_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [AXI_DATA_W-1:0] wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic      [1:0]            bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic      [AXI_DATA_W-1:0] rdata,
  output logic      [1:0]            rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic [DATA_W-1:0]     core_sample,
  input  wire logic                  core_above,
  input  wire logic                  core_below,
  input  wire logic                  mode_select_low,
  input  wire logic                  mode_select_high,
  input  wire logic                  reference_source_select,
  input  wire logic                  output_enable_n,
  output logic      [DATA_W-1:0]     data_out,
  output logic                       data_oe,
  output logic                       over_range_pin,
  output logic                       power_down,
  output logic                       gain_half,
  output logic                       use_external_ref,
  output logic                       irq
);

  // ==========================================================================
  // Functions
  // Clamp out-of-span results to the code ends
  function automatic logic [DATA_W-1:0] encode(input logic [DATA_W-1:0] s,
                                               input logic hi, input logic lo);
    if (hi) begin
      encode = CODE_FULL;
    end else if (lo) begin
      encode = CODE_ZERO;
    end else begin
      encode = s;
    end
  endfunction

  // Merge byte lane 0 of a write into a narrow field
  function automatic logic [INT_W-1:0] lane0(input logic [INT_W-1:0] old,
                                             input logic [AXI_DATA_W-1:0] d,
                                             input logic [3:0] be);
    lane0 = be[0] ? d[INT_W-1:0] : old;
  endfunction

  // ==========================================================================
  // Pin synchronisers {oe_n, ref, mode_hi, mode_lo}
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic [3:0] nxt_pin_s1;

  always_comb begin
    nxt_pin_s1 = {output_enable_n, reference_source_select, mode_select_high,
                  mode_select_low};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_ff <= 4'h8;
      pin_s2_ff <= 4'h8;
    end else begin
      pin_s1_ff <= nxt_pin_s1;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // ==========================================================================
  // Mode, sampling and output stage
  logic [1:0]        mode_s;
  logic              standby_ff, nxt_standby;
  logic              pd_ff, nxt_pd;
  logic              half_ff, nxt_half;
  logic              ext_ff, nxt_ext;
  logic              oe_ff, nxt_oe;
  logic [DATA_W-1:0] samp_ff, nxt_samp;
  logic              samp_rng_ff, nxt_samp_rng;
  logic [DATA_W:0]   pipe_q;
  logic [DATA_W-1:0] dout_ff, nxt_dout;
  logic              rng_ff, nxt_rng;
  logic [1:0]        prev_mode_ff;
  logic [FILL_W-1:0] fill_ff, nxt_fill;
  logic              mode_evt, bad_evt;
  logic              wr_do;
  logic [7:0]        wr_addr_ff;
  logic [AXI_DATA_W-1:0] wr_data_ff;
  logic [3:0]        wr_strb_ff;

  assign mode_s   = pin_s2_ff[1:0];
  assign mode_evt = (mode_s != prev_mode_ff);
  assign bad_evt  = mode_evt && (mode_s == MODE_BAD);

  // Decode pins and software standby, capture and encode samples
  always_comb begin
    nxt_standby = standby_ff;
    if (wr_do && wr_addr_ff == OFS_CTRL && wr_strb_ff[0]) begin
      nxt_standby = wr_data_ff[CTRL_STANDBY_BIT];
    end
    // Unused pattern 11 is parked in power-down as well
    nxt_pd   = standby_ff || mode_s == MODE_DOWN || mode_s == MODE_BAD;
    nxt_half = (mode_s == MODE_HALF);
    nxt_ext  = pin_s2_ff[2];
    nxt_oe   = !pin_s2_ff[3];
    // Sample taken at this edge, zero while powered down
    nxt_samp     = pd_ff ? CODE_ZERO : encode(core_sample, core_above, core_below);
    nxt_samp_rng = !pd_ff && (core_above || core_below);
    nxt_dout     = pipe_q[DATA_W-1:0];
    nxt_rng      = pipe_q[DATA_W];
    // Refill counter, tells software when output words are trustworthy
    if (pd_ff || mode_evt) begin
      nxt_fill = '0;
    end else if (fill_ff != FILL_W'(LATENCY)) begin
      nxt_fill = fill_ff + FILL_W'(1);
    end else begin
      nxt_fill = fill_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby_ff   <= CTRL_STANDBY_RST;
      pd_ff        <= 1'b1;
      half_ff      <= 1'b0;
      ext_ff       <= 1'b0;
      oe_ff        <= 1'b0;
      samp_ff      <= CODE_ZERO;
      samp_rng_ff  <= 1'b0;
      dout_ff      <= CODE_ZERO;
      rng_ff       <= 1'b0;
      prev_mode_ff <= MODE_DOWN;
      fill_ff      <= '0;
    end else begin
      standby_ff   <= nxt_standby;
      pd_ff        <= nxt_pd;
      half_ff      <= nxt_half;
      ext_ff       <= nxt_ext;
      oe_ff        <= nxt_oe;
      samp_ff      <= nxt_samp;
      samp_rng_ff  <= nxt_samp_rng;
      dout_ff      <= nxt_dout;
      rng_ff       <= nxt_rng;
      prev_mode_ff <= mode_s;
      fill_ff      <= nxt_fill;
    end
  end

  // Word and flag share one delay line so they never part
  asoc_delay #(.WIDTH(DATA_W + 1), .DEPTH(LATENCY - 1)) u_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({samp_rng_ff, samp_ff}),
    .dout    (pipe_q)
  );

  // ==========================================================================
  // Interrupt status and mask
  logic [INT_W-1:0] int_stat_ff, nxt_int_stat;
  logic [INT_W-1:0] int_mask_ff, nxt_int_mask;
  logic [INT_W-1:0] int_evt, int_clr;
  logic             irq_ff, nxt_irq;

  // Sticky set wins over a same-cycle write-one clear
  always_comb begin
    int_evt = '0;
    int_evt[INT_RANGE_BIT] = nxt_rng;
    int_evt[INT_MODE_BIT] = mode_evt;
    int_evt[INT_BAD_BIT]  = bad_evt;
    int_clr = '0;
    nxt_int_mask = int_mask_ff;
    if (wr_do && wr_addr_ff == OFS_INT_STAT) begin
      int_clr = lane0('0, wr_data_ff, wr_strb_ff);
    end
    if (wr_do && wr_addr_ff == OFS_INT_MASK) begin
      nxt_int_mask = lane0(int_mask_ff, wr_data_ff, wr_strb_ff);
    end
    nxt_int_stat = (int_stat_ff & ~int_clr) | int_evt;
    nxt_irq      = |(nxt_int_stat & nxt_int_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat_ff <= '0;
      int_mask_ff <= INT_MASK_RST;
      irq_ff      <= 1'b0;
    end else begin
      int_stat_ff <= nxt_int_stat;
      int_mask_ff <= nxt_int_mask;
      irq_ff      <= nxt_irq;
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic [7:0] nxt_wr_addr;
  logic [AXI_DATA_W-1:0] nxt_wr_data;
  logic [3:0] nxt_wr_strb;

  assign wr_do = aw_hold_ff && w_hold_ff && !bvalid_ff;

  // Address and data taken in either order, answer once both are held
  always_comb begin
    nxt_aw_hold = aw_hold_ff || (awvalid && awready_ff);
    nxt_w_hold  = w_hold_ff || (wvalid && wready_ff);
    nxt_wr_addr = (awvalid && awready_ff) ? awaddr : wr_addr_ff;
    nxt_wr_data = (wvalid && wready_ff) ? wdata : wr_data_ff;
    nxt_wr_strb = (wvalid && wready_ff) ? wstrb : wr_strb_ff;
    nxt_bvalid  = bvalid_ff && !bready;
    nxt_bresp   = bresp_ff;
    if (wr_do) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = (wr_addr_ff == OFS_CTRL || wr_addr_ff == OFS_INT_STAT ||
                     wr_addr_ff == OFS_INT_MASK) ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_awready = !nxt_aw_hold && !nxt_bvalid;
    nxt_wready  = !nxt_w_hold && !nxt_bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      wr_addr_ff <= '0;
      wr_data_ff <= '0;
      wr_strb_ff <= '0;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      wr_strb_ff <= nxt_wr_strb;
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  logic                  arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [AXI_DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [1:0]            rresp_ff, nxt_rresp;

  // Answer one cycle after the address is taken
  always_comb begin
    nxt_rvalid = rvalid_ff && !rready;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = '0;
      nxt_rresp  = RESP_OKAY;
      case (araddr)
        OFS_CTRL: nxt_rdata[CTRL_STANDBY_BIT] = standby_ff;
        OFS_STATUS: begin
          nxt_rdata[STAT_MODE_LSB +: 2] = mode_s;
          nxt_rdata[STAT_EXT_REF_BIT]   = ext_ff;
          nxt_rdata[STAT_OE_BIT]        = oe_ff;
          nxt_rdata[STAT_READY_BIT]     = (fill_ff == FILL_W'(LATENCY));
          nxt_rdata[STAT_PD_BIT]        = pd_ff;
          nxt_rdata[STAT_HALF_BIT]      = half_ff;
        end
        OFS_INT_STAT: nxt_rdata[INT_W-1:0] = int_stat_ff;
        OFS_INT_MASK: nxt_rdata[INT_W-1:0] = int_mask_ff;
        OFS_RESULT:   nxt_rdata[RESULT_RANGE_BIT:0] = {rng_ff, dout_ff};
        default:      nxt_rresp = RESP_SLVERR;
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= RESP_OKAY;
    end else begin
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // ==========================================================================
  // Outputs
  assign awready          = awready_ff;
  assign wready           = wready_ff;
  assign bvalid           = bvalid_ff;
  assign bresp            = bresp_ff;
  assign arready          = arready_ff;
  assign rvalid           = rvalid_ff;
  assign rdata            = rdata_ff;
  assign rresp            = rresp_ff;
  assign data_out         = dout_ff;
  assign data_oe          = oe_ff;
  assign over_range_pin   = rng_ff;
  assign power_down       = pd_ff;
  assign gain_half        = half_ff;
  assign use_external_ref = ext_ff;
  assign irq              = irq_ff;

  // ==========================================================================
  // Assertions
  logic [2:0] up_cnt_ff;

  // Cycles since reset, saturating, so history checks start clean
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_cnt_ff <= '0;
    end else if (up_cnt_ff != 3'h7) begin
      up_cnt_ff <= up_cnt_ff + 3'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rng_taken;
    !pd_ff && (core_above || core_below);
  endsequence
  sequence s_oe_on;
    $fell(output_enable_n) ##1 !output_enable_n [*2];
  endsequence

  property p_latency;
    up_cnt_ff == 3'h7 |-> dout_ff == $past(nxt_samp, 6);
  endproperty
  a_latency: assert property (p_latency) else $error("result latency wrong");
  property p_powerdown;
    mode_s == MODE_DOWN |=> pd_ff;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("no power-down");
  property p_gain;
    (mode_s == MODE_X1 && !standby_ff |=> !pd_ff && !half_ff) and
    (mode_s == MODE_HALF && !standby_ff |=> !pd_ff && half_ff);
  endproperty
  a_gain: assert property (p_gain) else $error("gain decode wrong");
  property p_release;
    output_enable_n [*3] |=> !oe_ff;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_clamp;
    (!pd_ff && core_above |=> samp_ff == CODE_FULL) and
    (!pd_ff && !core_above && core_below |=> samp_ff == CODE_ZERO);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp code wrong");
  property p_rng;
    s_rng_taken |-> ##6 rng_ff;
  endproperty
  a_rng: assert property (p_rng) else $error("over-range flag misaligned");
  property p_ref;
    reference_source_select [*3] |=> ext_ff;
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");
  property p_oe_on;
    s_oe_on |=> oe_ff;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not enabled");

endmodule // asoc_top

// file: shared/asoc_pkg.sv
// Package: register map, field layout, reset values and pipeline figures
package asoc_pkg;

  // ==========================================================================
  // Data path
  localparam int DATA_W     = 12;
  localparam int LATENCY    = 5;
  localparam int FILL_W     = 3;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0c;
  localparam logic [7:0] OFS_RESULT   = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int CTRL_STANDBY_BIT = 0;
  localparam int STAT_MODE_LSB    = 0;
  localparam int STAT_EXT_REF_BIT = 2;
  localparam int STAT_OE_BIT      = 3;
  localparam int STAT_READY_BIT   = 4;
  localparam int STAT_PD_BIT      = 5;
  localparam int STAT_HALF_BIT    = 6;
  localparam int INT_RANGE_BIT    = 0;
  localparam int INT_MODE_BIT     = 1;
  localparam int INT_BAD_BIT      = 2;
  localparam int INT_W            = 3;
  localparam int RESULT_RANGE_BIT = 12;

  // ==========================================================================
  // Mode pin codes {mode_select_high, mode_select_low}
  localparam logic [1:0] MODE_DOWN = 2'h0;
  localparam logic [1:0] MODE_X1   = 2'h1;
  localparam logic [1:0] MODE_HALF = 2'h2;
  localparam logic [1:0] MODE_BAD  = 2'h3;

  // ==========================================================================
  // Reset values and codes
  localparam logic             CTRL_STANDBY_RST = 1'h0;
  localparam logic [INT_W-1:0] INT_MASK_RST     = 3'h0;
  localparam logic [11:0]      CODE_FULL        = 12'hfff;
  localparam logic [11:0]      CODE_ZERO        = 12'h000;
  localparam logic [1:0]       RESP_OKAY        = 2'h0;
  localparam logic [1:0]       RESP_SLVERR      = 2'h2;

endpackage

// file: tb/asoc_capture.sv
// Capture-side model: latches the resolved data bus and flag each edge
module asoc_capture
  import asoc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe,
  input  wire logic              over_range_pin,
  input  wire logic              power_down,
  input  wire logic              gain_half,
  output logic      [DATA_W-1:0] cap_word,
  output logic                   cap_flag,
  output logic                   cap_ok
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [DATA_W-1:0] last_word;
  logic [2:0]        clean_cnt;
  logic              last_half;
  logic [DATA_W-1:0] bus_word;

  // ==========================================================================
  // Released bus shows the inverse of the last driven word
  assign bus_word = data_oe ? data_out : ~last_word;
  assign cap_ok   = (clean_cnt == 3'h5);

  // Word and flag taken on the same edge, refill counted
  always @(posedge aclk) begin
    if (data_oe) begin
      last_word <= data_out;
    end
    cap_word  <= bus_word;
    cap_flag  <= over_range_pin;
    last_half <= gain_half;
    if (!aresetn || power_down || (gain_half != last_half)) begin
      clean_cnt <= 3'h0;
    end else if (clean_cnt < 3'h5) begin
      clean_cnt <= clean_cnt + 3'h1;
    end
  end
endmodule // asoc_capture

// file: tb/testbench.sv
// Testbench: pins, result stream, registers and interrupt
module testbench import asoc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Stimulus and observed signals
  logic                  aclk = 1'b0;
  logic                  aresetn = 1'b0;
  logic [AXI_ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [AXI_DATA_W-1:0] wdata = 32'h0, rdata;
  logic [3:0]            wstrb = 4'h0;
  logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                  arvalid = 1'b0, rready = 1'b0;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [1:0]            bresp, rresp;
  logic [DATA_W-1:0]     core_sample = 12'h000, data_out, cap_word;
  logic                  core_above = 1'b0, core_below = 1'b0;
  logic                  mode_select_low = 1'b1, mode_select_high = 1'b0;
  logic                  reference_source_select = 1'b0, output_enable_n = 1'b0;
  logic                  data_oe, over_range_pin, power_down, gain_half;
  logic                  use_external_ref, irq, cap_flag, cap_ok;
  logic [12:0]           expw [0:23];
  int                    fails = 0;
  int                    compares = 0;

  // Clock at 25 MHz
  always #20 aclk = ~aclk;

  asoc_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .core_sample(core_sample),
    .core_above(core_above), .core_below(core_below),
    .mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
    .reference_source_select(reference_source_select),
    .output_enable_n(output_enable_n), .data_out(data_out), .data_oe(data_oe),
    .over_range_pin(over_range_pin), .power_down(power_down),
    .gain_half(gain_half), .use_external_ref(use_external_ref), .irq(irq)
  );

  asoc_capture i_cap (
    .aclk(aclk), .aresetn(aresetn), .data_out(data_out), .data_oe(data_oe),
    .over_range_pin(over_range_pin), .power_down(power_down),
    .gain_half(gain_half), .cap_word(cap_word), .cap_flag(cap_flag), .cap_ok(cap_ok)
  );

  // ==========================================================================
  // Compare and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Register bus master
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    // Let one edge pass so a following call never re-raises bready in this step
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // Let one edge pass so a following call never re-raises rready in this step
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    chk(d & msk, e);
    chk(32'(r), 32'(er));
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axi_write(a, d, r);
    chk(32'(r), 32'(er));
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (3000) @(posedge aclk);
    fails++;
    test_done();
  end

  // Main sequence
  initial begin
    logic        pd;
    logic [11:0] s;
    logic        ab;
    logic        bl;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd_chk(OFS_CTRL, 32'hffffffff, 32'h0, RESP_OKAY);
    rd_chk(OFS_INT_MASK, 32'hffffffff, 32'h0, RESP_OKAY);
    rd_chk(8'h20, 32'hffffffff, 32'h0, RESP_SLVERR);
    wr_chk(OFS_RESULT, 32'h1, RESP_SLVERR);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      mode_select_high <= m[1];
      mode_select_low <= m[0];
      repeat (5) @(posedge aclk);
      pd = (m == 0) || (m == 3);
      chk(32'(power_down), 32'(pd));
      chk(32'(gain_half), 32'(m == 2));
      rd_chk(OFS_STATUS, 32'h63, 32'(m) | (32'(pd) << STAT_PD_BIT) |
             (32'(m == 2) << STAT_HALF_BIT), RESP_OKAY);
    end
    mode_select_high <= 1'b0;
    mode_select_low <= 1'b1;
    repeat (10) @(posedge aclk);
    $display("test modes done");
    for (int i = 0; i < 31; i++) begin
      @(posedge aclk);
      if (i < 24) begin
        s = 12'(i * 163 + 5);
        ab = (i % 7 == 3);
        bl = (i % 7 == 5);
        core_sample <= s;
        core_above <= ab;
        core_below <= bl;
        expw[i] = ab ? {1'b1, CODE_FULL} : (bl ? {1'b1, CODE_ZERO} : {1'b0, s});
      end else begin
        core_above <= 1'b0;
        core_below <= 1'b0;
      end
      #1;
      if (i >= 7) begin
        chk(32'({cap_flag, cap_word}), 32'(expw[i - 7]));
        chk(32'(cap_ok), 32'h1);
      end
    end
    // Back onto the rising edge before the bus is driven again
    @(posedge aclk);
    $display("test stream done");
    chk(32'(irq), 32'h0);
    rd_chk(OFS_INT_STAT, 32'h1, 32'h1, RESP_OKAY);
    wr_chk(OFS_INT_STAT, 32'h6, RESP_OKAY);
    wr_chk(OFS_INT_MASK, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h1);
    wr_chk(OFS_INT_STAT, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    rd_chk(OFS_INT_STAT, 32'h7, 32'h0, RESP_OKAY);
    $display("test interrupt done");
    reference_source_select <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'(use_external_ref), 32'h1);
    rd_chk(OFS_STATUS, 32'h4, 32'h4, RESP_OKAY);
    reference_source_select <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(32'(use_external_ref), 32'h0);
    // Software standby forces power-down and zero words with no flag
    wr_chk(OFS_CTRL, 32'h1, RESP_OKAY);
    repeat (8) @(posedge aclk);
    chk(32'(power_down), 32'h1);
    chk(32'({cap_flag, cap_word}), 32'h0);
    rd_chk(OFS_STATUS, 32'h20, 32'h20, RESP_OKAY);
    wr_chk(OFS_CTRL, 32'h0, RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk(32'(power_down), 32'h0);
    output_enable_n <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'(data_oe), 32'h0);
    rd_chk(OFS_STATUS, 32'h8, 32'h0, RESP_OKAY);
    output_enable_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(32'(data_oe), 32'h1);
    $display("test pins done");
    test_done();
  end
endmodule // testbench
